// ===== inc/lsb_pkg.sv
// Constants, register map and helpers for the LIN serial break/header block
package lsb_pkg;
   localparam logic [7:0]  OFS_STATUS    = 8'h00;
   localparam logic [7:0]  OFS_DATA      = 8'h04;
   localparam logic [7:0]  OFS_CTRL1     = 8'h08;
   localparam logic [7:0]  OFS_CTRL2     = 8'h0C;
   localparam logic [7:0]  OFS_CTRL3     = 8'h10;
   localparam logic [7:0]  OFS_HLEN      = 8'h14;
   localparam logic [7:0]  OFS_BAUD      = 8'h18;
   localparam logic [7:0]  OFS_IRQ_ST    = 8'h1C;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h20;
   localparam logic [7:0]  OFS_IRQ_EN    = 8'h24;
   localparam int          POS_RX_FULL   = 0;
   localparam int          POS_HDR_ERR   = 1;
   localparam int          POS_HDR_DET   = 2;
   localparam int          POS_TX_FREE   = 3;
   localparam int          POS_MUTE_ST   = 4;
   localparam int          POS_WORD9     = 0;
   localparam int          POS_BREAK     = 0;
   localparam int          POS_MUTE      = 1;
   localparam int          POS_RX_EN     = 2;
   localparam int          POS_TX_EN     = 3;
   localparam int          POS_LIN_EN    = 0;
   localparam int          POS_LIN_SLV   = 1;
   localparam logic [15:0] BAUD_RESET    = 16'h0033;
   localparam logic [2:0]  IRQ_RESET     = 3'h0;
   localparam logic [3:0]  SAMPLES_LAST  = 4'hF;
   localparam logic [3:0]  SAMPLE_MID    = 4'h7;
   localparam logic [3:0]  WIN_FIRST     = 4'h8;
   localparam logic [3:0]  WIN_LAST      = 4'hE;
   localparam logic [3:0]  DATA_LAST_8   = 4'h7;
   localparam logic [3:0]  DATA_LAST_9   = 4'h8;
   localparam logic [7:0]  HDR_MAX_BITS  = 8'h39;
   localparam logic [7:0]  HDR_BRK_BITS  = 8'h0A;
   localparam logic [7:0]  SYNC_BYTE     = 8'h55;
   localparam logic [3:0]  BRK_BITS_8    = 4'hA;
   localparam logic [3:0]  BRK_BITS_9    = 4'hB;
   localparam logic [3:0]  BRK_BITS_LIN  = 4'hD;
   localparam logic [3:0]  IDLE_BITS     = 4'hA;
   localparam logic [3:0]  FRAME_BITS_8  = 4'hA;
   localparam logic [3:0]  FRAME_BITS_9  = 4'hB;

   function automatic logic [3:0] lsb_brk_bits(input logic line,
                                                input logic m);
      if (line && !m)
         return BRK_BITS_LIN;
      else if (m)
         return BRK_BITS_9;
      else
         return BRK_BITS_8;
   endfunction

   function automatic logic [3:0] lsb_frame_bits(input logic m);
      return m ? FRAME_BITS_9 : FRAME_BITS_8;
   endfunction
endpackage

// ===== inc/lsb_if.sv
// Link between the controller, its baud generator and its transmitter
interface lsb_if;
   logic        tick;
   logic [15:0] div;
   logic        te;
   logic        m;
   logic [8:0]  data;
   logic        data_req;
   logic        data_ack;
   logic        idle_req;
   logic        idle_ack;
   logic        brk_req;
   logic [3:0]  brk_bits;
   logic        brk_start;
   logic        busy;
   modport baud (input div, output tick);
   modport tx (input tick, te, m, data, data_req, idle_req, brk_req,
               brk_bits, output data_ack, idle_ack, brk_start, busy);
   modport ctl (output div, te, m, data, data_req, idle_req, brk_req,
                brk_bits, input tick, data_ack, idle_ack, brk_start, busy);
endinterface

// ===== hw/lsb_baud.sv
// Sample tick generator, sixteen ticks per bit
module lsb_baud import lsb_pkg::*; (
   input  wire logic pclk,
   input  wire logic presetn,
   lsb_if.baud       bus
);
   logic [15:0] cnt;

   // Tick every div+1 clocks gives one sixteenth of a bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         bus.tick <= 1'b0;
      end else if (cnt >= bus.div) begin
         cnt <= 16'h0000;
         bus.tick <= 1'b1;
      end else begin
         cnt <= 16'(cnt + 16'h0001);
         bus.tick <= 1'b0;
      end
   end
endmodule

// ===== hw/lsb_tx.sv
// Transmitter: idle characters, break characters and data frames
module lsb_tx import lsb_pkg::*; (
   input  wire logic pclk,
   input  wire logic presetn,
   lsb_if.tx         bus,
   output logic      txd
);
   logic [12:0] shreg;
   logic [3:0]  nleft;
   logic [3:0]  scnt;

   // Idle first, then break, then data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg <= 13'h1FFF;
         nleft <= 4'h0;
         scnt <= 4'h0;
         bus.busy <= 1'b0;
         bus.idle_ack <= 1'b0;
         bus.data_ack <= 1'b0;
         bus.brk_start <= 1'b0;
      end else begin
         bus.idle_ack <= 1'b0;
         bus.data_ack <= 1'b0;
         bus.brk_start <= 1'b0;
         if (!bus.busy) begin
            scnt <= 4'h0;
            if (bus.te && bus.idle_req) begin
               shreg <= 13'h1FFF;
               nleft <= IDLE_BITS;
               bus.busy <= 1'b1;
               bus.idle_ack <= 1'b1;
            end else if (bus.te && bus.brk_req) begin
               shreg <= 13'(13'h1FFF << bus.brk_bits);
               nleft <= 4'(bus.brk_bits + 4'h1);
               bus.busy <= 1'b1;
               bus.brk_start <= 1'b1;
            end else if (bus.te && bus.data_req) begin
               if (bus.m)
                  shreg <= {3'h7, bus.data, 1'b0};
               else
                  shreg <= {4'hF, bus.data[7:0], 1'b0};
               nleft <= lsb_frame_bits(bus.m);
               bus.busy <= 1'b1;
               bus.data_ack <= 1'b1;
            end
         end else if (bus.tick) begin
            scnt <= 4'(scnt + 4'h1);
            if (scnt == SAMPLES_LAST) begin
               shreg <= {1'b1, shreg[12:1]};
               nleft <= 4'(nleft - 4'h1);
               if (nleft == 4'h1)
                  bus.busy <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         txd <= 1'b1;
      else
         txd <= bus.busy ? shreg[0] : 1'b1;
   end

   property p_brk_len;
      @(posedge pclk) disable iff (!presetn)
      bus.brk_start |-> nleft == 4'($past(bus.brk_bits) + 4'h1) && !shreg[0];
   endproperty
   a_brk_len: assert property (p_brk_len)
      else $error("break length not loaded");

   property p_brk_repeat;
      @(posedge pclk) disable iff (!presetn)
      !bus.busy && bus.te && bus.brk_req && !bus.idle_req |=> bus.brk_start;
   endproperty
   a_brk_repeat: assert property (p_brk_repeat)
      else $error("break not started while requested");

   property p_idle_len;
      @(posedge pclk) disable iff (!presetn)
      bus.idle_ack |-> nleft == IDLE_BITS && shreg == 13'h1FFF;
   endproperty
   a_idle_len: assert property (p_idle_len)
      else $error("idle character length wrong");

   c_break: cover property (@(posedge pclk) disable iff (!presetn)
      bus.brk_start);
endmodule

// ===== hw/lsb_top.sv
// Serial controller with LIN header reception, mute and break generation
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module lsb_top import lsb_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT
   } lsb_rx_t;

   lsb_if bus ();

   logic        acc;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        unmapped;
   logic        m_bit;
   logic        te;
   logic        re;
   logic        send_break_bit;
   logic        receiver_wakeup_mute_bit;
   logic        line;
   logic        lslv;
   logic [15:0] div;
   logic [2:0]  irq_en;
   logic [2:0]  irq_st;
   logic        receive_full_flag;
   logic        header_error_flag;
   logic        header_detected_flag;
   logic [8:0]  rx_data;
   logic [7:0]  hlen;
   logic [8:0]  tx_buf;
   logic        tx_pend;
   logic        idle_pend;
   logic        armed;
   lsb_rx_t     rx_st;
   logic [3:0]  scnt;
   logic [3:0]  bitn;
   logic [8:0]  shreg;
   logic        stop_bit;
   logic [8:0]  rx_word;
   logic        hdr_act;
   logic        hdr_byte;
   logic [3:0]  hcnt;
   logic [7:0]  hdr_bits;
   logic        lin_slave;
   logic        byte_done;
   logic        frame_end;
   logic        brk_seen;
   logic        timeout;
   logic        in_win;
   logic        win_to;
   logic        sync_err;
   logic        hdr_ok;
   logic        receive_full_flag_set;
   logic        lhe_set;
   logic        data_clr;
   logic        wr_c2;
   logic [2:0]  next_irq_st;

   function automatic logic hit(input logic [7:0] ofs);
      return paddr == ofs;
   endfunction

   lsb_baud u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (bus.baud)
   );

   lsb_tx u_tx (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (bus.tx),
      .txd     (txd)
   );

   assign bus.div = div;
   assign bus.te = te;
   assign bus.m = m_bit;
   assign bus.data = tx_buf;
   assign bus.data_req = tx_pend;
   assign bus.idle_req = idle_pend;
   assign bus.brk_req = send_break_bit;
   assign bus.brk_bits = lsb_brk_bits(line, m_bit);

   // APB: one wait state, effects at the edge that samples pready high
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign wr_c2 = wr & hit(OFS_CTRL2);

   always_comb begin
      rdata = 32'h0000_0000;
      unmapped = 1'b0;
      if (hit(OFS_STATUS)) begin
         rdata[POS_RX_FULL] = receive_full_flag;
         rdata[POS_HDR_ERR] = header_error_flag;
         rdata[POS_HDR_DET] = header_detected_flag;
         rdata[POS_TX_FREE] = ~tx_pend;
         rdata[POS_MUTE_ST] = receiver_wakeup_mute_bit;
      end else if (hit(OFS_DATA)) begin
         rdata[8:0] = rx_data;
      end else if (hit(OFS_CTRL1)) begin
         rdata[POS_WORD9] = m_bit;
      end else if (hit(OFS_CTRL2)) begin
         rdata[POS_BREAK] = send_break_bit;
         rdata[POS_MUTE] = receiver_wakeup_mute_bit;
         rdata[POS_RX_EN] = re;
         rdata[POS_TX_EN] = te;
      end else if (hit(OFS_CTRL3)) begin
         rdata[POS_LIN_EN] = line;
         rdata[POS_LIN_SLV] = lslv;
      end else if (hit(OFS_HLEN)) begin
         rdata[7:0] = hlen;
      end else if (hit(OFS_BAUD)) begin
         rdata[15:0] = div;
      end else if (hit(OFS_IRQ_ST)) begin
         rdata[2:0] = irq_st;
      end else if (hit(OFS_IRQ_CLR)) begin
         rdata = 32'h0000_0000;
      end else if (hit(OFS_IRQ_EN)) begin
         rdata[2:0] = irq_en;
      end else begin
         unmapped = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= unmapped;
         prdata <= pwrite ? 32'h0000_0000 : rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_bit <= 1'b0;
         te <= 1'b0;
         re <= 1'b0;
         send_break_bit <= 1'b0;
         line <= 1'b0;
         lslv <= 1'b0;
         div <= BAUD_RESET;
         irq_en <= IRQ_RESET;
      end else if (wr) begin
         if (hit(OFS_CTRL1)) begin
            m_bit <= pwdata[POS_WORD9];
         end else if (hit(OFS_CTRL2)) begin
            te <= pwdata[POS_TX_EN];
            re <= pwdata[POS_RX_EN];
            send_break_bit <= pwdata[POS_BREAK];
         end else if (hit(OFS_CTRL3)) begin
            line <= pwdata[POS_LIN_EN];
            lslv <= pwdata[POS_LIN_SLV];
         end else if (hit(OFS_BAUD)) begin
            div <= pwdata[15:0];
         end else if (hit(OFS_IRQ_EN)) begin
            irq_en <= pwdata[2:0];
         end
      end
   end

   // Idle request on a transmitter enable rising by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         idle_pend <= 1'b0;
      else if (wr_c2 && pwdata[POS_TX_EN] && !te)
         idle_pend <= 1'b1;
      else if (bus.idle_ack)
         idle_pend <= 1'b0;
   end

   // Transmit data holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf <= 9'h000;
         tx_pend <= 1'b0;
      end else if (wr && hit(OFS_DATA)) begin
         tx_buf <= pwdata[8:0];
         tx_pend <= 1'b1;
      end else if (bus.data_ack) begin
         tx_pend <= 1'b0;
      end
   end

   // Status read arms the clear, data read completes it
   assign data_clr = rd & hit(OFS_DATA) & armed;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         armed <= 1'b0;
      else if (rd && hit(OFS_STATUS))
         armed <= 1'b1;
      else if (rd && hit(OFS_DATA))
         armed <= 1'b0;
   end

   // Receiver, sampling at the sixteen-per-bit tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= RX_IDLE;
         scnt <= 4'h0;
         bitn <= 4'h0;
         shreg <= 9'h000;
         stop_bit <= 1'b0;
      end else if (!re) begin
         rx_st <= RX_IDLE;
         scnt <= 4'h0;
      end else if (bus.tick) begin
         scnt <= 4'(scnt + 4'h1);
         case (rx_st)
            RX_IDLE: begin
               scnt <= 4'h0;
               if (!rxd)
                  rx_st <= RX_START;
            end
            RX_START: begin
               if (scnt == SAMPLE_MID && rxd)
                  rx_st <= RX_IDLE;
               else if (scnt == SAMPLES_LAST) begin
                  rx_st <= RX_DATA;
                  bitn <= 4'h0;
               end
            end
            RX_DATA: begin
               if (scnt == SAMPLE_MID)
                  shreg <= {rxd, shreg[8:1]};
               if (scnt == SAMPLES_LAST) begin
                  if (bitn == (m_bit ? DATA_LAST_9 : DATA_LAST_8))
                     rx_st <= RX_STOP;
                  bitn <= 4'(bitn + 4'h1);
               end
            end
            RX_STOP: begin
               if (scnt == SAMPLE_MID)
                  stop_bit <= rxd;
               if (scnt == SAMPLES_LAST)
                  rx_st <= stop_bit ? RX_IDLE : RX_WAIT;
            end
            RX_WAIT: begin
               scnt <= 4'h0;
               if (rxd)
                  rx_st <= RX_IDLE;
            end
            default: rx_st <= RX_IDLE;
         endcase
      end
   end

   assign rx_word = m_bit ? shreg : {1'b0, shreg[8:1]};
   assign byte_done = re & bus.tick & (rx_st == RX_STOP) &
                      (scnt == WIN_LAST) & stop_bit;
   assign frame_end = re & bus.tick & (rx_st == RX_STOP) &
                      (scnt == SAMPLES_LAST);
   // Break taken at the frame's last sample so its own end is not a sync byte
   assign brk_seen = re & bus.tick & (rx_st == RX_STOP) &
                     (scnt == SAMPLES_LAST) & ~stop_bit & (rx_word == 9'h000);

   // Header tracking in LIN slave mode
   assign lin_slave = line & lslv;
   assign timeout = hdr_act & bus.tick & (hcnt == SAMPLES_LAST) &
                    (hdr_bits == HDR_MAX_BITS);
   assign in_win = hdr_act & hdr_byte & (rx_st == RX_STOP) &
                   (scnt >= WIN_FIRST) & (scnt <= WIN_LAST);
   assign win_to = timeout & in_win;
   assign sync_err = hdr_act & ~hdr_byte & frame_end & ~timeout & ~brk_seen &
                     ((rx_word[7:0] != SYNC_BYTE) | ~stop_bit);
   assign hdr_ok = hdr_act & hdr_byte & frame_end & stop_bit & ~timeout;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdr_act <= 1'b0;
         hdr_byte <= 1'b0;
         hcnt <= 4'h0;
         hdr_bits <= 8'h00;
      end else if (!lin_slave) begin
         hdr_act <= 1'b0;
      end else if (brk_seen) begin
         hdr_act <= 1'b1;
         hdr_byte <= 1'b0;
         hcnt <= 4'h0;
         hdr_bits <= HDR_BRK_BITS;
      end else if (hdr_act) begin
         if (bus.tick) begin
            hcnt <= 4'(hcnt + 4'h1);
            if (hcnt == SAMPLES_LAST)
               hdr_bits <= 8'(hdr_bits + 8'h01);
         end
         if (timeout || sync_err || hdr_ok)
            hdr_act <= 1'b0;
         else if (frame_end)
            hdr_byte <= 1'b1;
      end
   end

   // Mute bit: software set wins over hardware wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         receiver_wakeup_mute_bit <= 1'b0;
      else if (wr_c2)
         receiver_wakeup_mute_bit <= pwdata[POS_MUTE];
      else if (hdr_ok)
         receiver_wakeup_mute_bit <= 1'b0;
      else if (win_to)
         receiver_wakeup_mute_bit <= 1'b0;
   end

   // Flags: set wins over the read-pair clear
   assign receive_full_flag_set = byte_done & ~receiver_wakeup_mute_bit;
   assign lhe_set = timeout | sync_err;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_full_flag <= 1'b0;
         header_error_flag <= 1'b0;
         header_detected_flag <= 1'b0;
      end else begin
         receive_full_flag <= receive_full_flag_set | (receive_full_flag & ~data_clr);
         header_error_flag <= lhe_set | (header_error_flag & ~data_clr);
         header_detected_flag <= hdr_ok | (header_detected_flag & ~data_clr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= 9'h000;
         hlen <= 8'h00;
      end else begin
         if (receive_full_flag_set)
            rx_data <= rx_word;
         if (timeout)
            hlen <= 8'h00;
         else if (sync_err || hdr_ok)
            hlen <= hdr_bits;
      end
   end

   // Interrupt status, clear and enable
   always_comb begin
      next_irq_st = irq_st;
      if (wr && hit(OFS_IRQ_CLR))
         next_irq_st = irq_st & ~pwdata[2:0];
      next_irq_st = next_irq_st | {hdr_ok, lhe_set, receive_full_flag_set};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_st <= next_irq_st;
         irq <= |(irq_st & irq_en);
      end
   end

   property p_to_flag;
      @(posedge pclk) disable iff (!presetn)
      timeout |=> header_error_flag && hlen == 8'h00 && irq_st[POS_HDR_ERR];
   endproperty
   a_to_flag: assert property (p_to_flag)
      else $error("time-out did not flag error with zero length");

   property p_to_mute;
      @(posedge pclk) disable iff (!presetn)
      timeout && !in_win && receiver_wakeup_mute_bit && !wr_c2 |=> receiver_wakeup_mute_bit && !header_detected_flag;
   endproperty
   a_to_mute: assert property (p_to_mute)
      else $error("left mute on time-out outside window");

   property p_win_wake;
      @(posedge pclk) disable iff (!presetn)
      win_to && !wr_c2 |=> !receiver_wakeup_mute_bit && header_error_flag && !$rose(header_detected_flag);
   endproperty
   a_win_wake: assert property (p_win_wake)
      else $error("window time-out did not wake");

   property p_full;
      @(posedge pclk) disable iff (!presetn)
      byte_done && !receiver_wakeup_mute_bit |=> receive_full_flag && irq_st[POS_RX_FULL];
   endproperty
   a_full: assert property (p_full)
      else $error("byte out of mute did not set receive full");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      data_clr && !receive_full_flag_set && !lhe_set |=> !receive_full_flag && !header_error_flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("read pair did not clear flags");

   property p_mute_set;
      @(posedge pclk) disable iff (!presetn)
      wr_c2 && pwdata[POS_MUTE] |=> receiver_wakeup_mute_bit ##1 (receiver_wakeup_mute_bit || $past(hdr_ok) ||
                                             $past(win_to) || $past(wr_c2));
   endproperty
   a_mute_set: assert property (p_mute_set)
      else $error("mute not entered on software write");

   property p_detect;
      @(posedge pclk) disable iff (!presetn)
      hdr_ok && !wr_c2 |=> header_detected_flag && !receiver_wakeup_mute_bit && hlen == $past(hdr_bits);
   endproperty
   a_detect: assert property (p_detect)
      else $error("valid header not detected");

   property p_lin_brk;
      @(posedge pclk) disable iff (!presetn)
      line && !m_bit |-> bus.brk_bits == BRK_BITS_LIN;
   endproperty
   a_lin_brk: assert property (p_lin_brk)
      else $error("LIN master break length wrong");

   property p_idle_q;
      @(posedge pclk) disable iff (!presetn)
      wr_c2 && pwdata[POS_TX_EN] && !te |=> idle_pend;
   endproperty
   a_idle_q: assert property (p_idle_q)
      else $error("idle not queued on enable toggle");

   property p_bit16;
      @(posedge pclk) disable iff (!presetn)
      re && bus.tick && rx_st == RX_START && scnt == SAMPLES_LAST
      |=> rx_st == RX_DATA && scnt == 4'h0;
   endproperty
   a_bit16: assert property (p_bit16)
      else $error("bit period is not sixteen samples");

   c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
      timeout && !in_win);
   c_win_to: cover property (@(posedge pclk) disable iff (!presetn)
      win_to ##[1:40] receive_full_flag_set);
   c_hdr_ok: cover property (@(posedge pclk) disable iff (!presetn)
      hdr_ok);
endmodule

// ===== tb/lsb_node.sv
// Remote serial node driving the receive line
module lsb_node (
   input  wire logic pclk,
   output logic      rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rxd = 1'b1;
   // Holds the line for whole bits of sixteen clocks
   task automatic bits(input logic v, input int n);
      rxd <= v;
      repeat (16 * n) @(posedge pclk);
   endtask
   // Start bit, data LSB first, high stop bit
   task automatic send(input logic [7:0] d);
      int i;
      bits(1'b0, 1);
      for (i = 0; i < 8; i++) begin
         bits(d[i], 1);
      end
      bits(1'b1, 1);
   endtask
endmodule

// ===== tb/lsb_top_tb.sv
// Self-checking bench for the LIN serial break and header block
module lsb_top_tb import lsb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata, r;
   logic         pready, pslverr, rxd, txd, irq, last_err;
   int           err_count = 0;
   int           samples_checked = 0;
   byte unsigned exp_q[$];
   int           n, k, m;
   int           bt[4] = '{10, 11, 13, 11};
   always #5 pclk = ~pclk;
   lsb_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
   lsb_node node_u (.pclk(pclk), .rxd(rxd));
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      samples_checked++;
      if (got !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] mk, e);
      apb(1'b0, a, 32'h0);
      chk(r & mk, e);
   endtask
   task automatic low_run(output int w, output int n);
      w = 0;
      n = 0;
      while (txd !== 1'b0 && w < 400) begin
         @(posedge pclk);
         w++;
      end
      while (txd === 1'b0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #300000;
      err_count++;
      final_report();
   end
   initial begin
      void'($urandom(32'h323ADB23));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_BAUD, 32'hFFFF, {16'h0, BAUD_RESET});
      rd(OFS_STATUS, 32'h17, 32'h0);
      rd(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk(last_err, 1'b1);
      wr(OFS_BAUD, 32'h0);
      $display("test reset done");
      for (m = 0; m < 4; m++) begin
         wr(OFS_CTRL1, 32'(m & 1));
         wr(OFS_CTRL3, 32'(m >> 1));
         wr(OFS_CTRL2, 32'h0);
         wr(OFS_CTRL2, 32'h8);
         wr(OFS_CTRL2, 32'h9);
         low_run(k, n);
         chk(k > 140, 1'b1);
         chk(n, 16 * bt[m]);
         low_run(k, n);
         chk(n, 16 * bt[m]);
         wr(OFS_CTRL2, 32'h8);
      end
      $display("test break done");
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_CTRL3, 32'h0);
      wr(OFS_CTRL2, 32'h4);
      for (m = 0; m < 2; m++) begin
         wr(OFS_IRQ_EN, m ? 32'h6 : 32'h7);
         exp_q.push_back(8'($urandom));
         node_u.send(exp_q[$]);
         node_u.bits(1'b1, 2);
         chk(irq, m == 0);
         rd(OFS_STATUS, 32'h1, 32'h1);
         rd(OFS_DATA, 32'hFF, {24'h0, exp_q.pop_front()});
         rd(OFS_STATUS, 32'h3, 32'h0);
         wr(OFS_IRQ_CLR, 32'h7);
         rd(OFS_IRQ_ST, 32'h7, 32'h0);
         chk(irq, 1'b0);
      end
      $display("test receive done");
      wr(OFS_IRQ_EN, 32'h7);
      wr(OFS_CTRL2, 32'h6);
      node_u.send(8'hA5);
      node_u.bits(1'b1, 2);
      rd(OFS_STATUS, 32'h11, 32'h10);
      wr(OFS_CTRL3, 32'h3);
      node_u.bits(1'b0, 13);
      node_u.bits(1'b1, 1);
      node_u.send(SYNC_BYTE);
      node_u.send(8'h3C);
      node_u.bits(1'b1, 2);
      rd(OFS_STATUS, 32'h16, 32'h4);
      rd(OFS_DATA, 32'h0, 32'h0);
      rd(OFS_STATUS, 32'h7, 32'h0);
      wr(OFS_IRQ_CLR, 32'h7);
      wr(OFS_CTRL2, 32'h6);
      node_u.bits(1'b0, 13);
      node_u.bits(1'b1, 1);
      node_u.send(SYNC_BYTE);
      node_u.bits(1'b1, 50);
      rd(OFS_STATUS, 32'h16, 32'h12);
      rd(OFS_HLEN, 32'hFF, 32'h0);
      chk(irq, 1'b1);
      rd(OFS_DATA, 32'h0, 32'h0);
      wr(OFS_IRQ_CLR, 32'h7);
      // Time-out lands on sample 11 of the identifier stop bit
      node_u.bits(1'b0, 13);
      node_u.bits(1'b1, 1);
      node_u.send(SYNC_BYTE);
      repeat (388) @(posedge pclk);
      node_u.send(8'h3C);
      node_u.bits(1'b1, 2);
      rd(OFS_STATUS, 32'h17, 32'h3);
      rd(OFS_IRQ_ST, 32'h7, 32'h3);
      rd(OFS_DATA, 32'hFF, 32'h3C);
      rd(OFS_HLEN, 32'hFF, 32'h0);
      $display("test header done");
      final_report();
   end
endmodule
